// File: verilog/wlsl_core.sv
// execution core for 16-bit loads and logical shift-left instructions
module wlsl_core
  import wlsl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // processor bus
  output logic [15:0]      busAddr,
  output logic             busReadWrite,
  output logic [7:0]       busWrData,
  input  wire logic [7:0]  busRdData,
  // architectural state
  output logic [7:0]       upperAccumulator,
  output logic [7:0]       lowerAccumulator,
  output logic [15:0]      stackPointerReg,
  output logic [15:0]      firstIndexReg,
  output logic [15:0]      secondIndexReg,
  output logic [7:0]       conditionFlagsReg,
  // status
  output logic             illegalOp
);
  wlsl_state_t state_q;
  wlsl_tgt_t   tgt_q;
  wlsl_am_t    am_q;
  logic [15:0] pc_q;
  logic [15:0] ea_q;
  logic [7:0]  hiByte_q;
  logic        pageY_q;
  logic        isShift_q;
  logic [7:0]  opc_q;

  // byte shift result of memory operand or accumulators
  logic [7:0]  shIn;
  logic [7:0]  shOut;
  logic [15:0] dblOut;
  logic [15:0] wideVal;
  always_comb begin
    shIn = busRdData;
    if (state_q == WLSL_INH && opc_q == OP_SHL_UP) begin
      shIn = upperAccumulator;
    end else if (state_q == WLSL_INH) begin
      shIn = lowerAccumulator;
    end
  end
  assign shOut   = {shIn[6:0], 1'b0};
  assign dblOut  = {upperAccumulator[6:0], lowerAccumulator, 1'b0};
  assign wideVal = {hiByte_q, busRdData};

  // decode of the main opcode byte
  function automatic logic decodeOk(input logic [7:0] op);
    decodeOk = (op[3:0] == 4'hC) || (op[3:0] == 4'hE) ||
               (op == OP_SHL_UP) || (op == OP_SHL_LO) ||
               (op == OP_SHL_EXT) || (op == OP_SHL_IND) ||
               (op == OP_SHL_DBL);
  endfunction

  // sequencer and bus
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= WLSL_FETCH;
      pc_q         <= RESET_PC;
      busAddr      <= RESET_PC;
      busReadWrite <= 1'b1;
      busWrData    <= ZERO_BYTE;
      ea_q         <= ZERO_WORD;
      hiByte_q     <= ZERO_BYTE;
      pageY_q      <= 1'b0;
      isShift_q    <= 1'b0;
      opc_q        <= ZERO_BYTE;
      tgt_q        <= WLSL_TGT_D;
      am_q         <= WLSL_AM_IMM;
      illegalOp    <= 1'b0;
    end else begin
      busReadWrite <= 1'b1;
      case (state_q)
        WLSL_FETCH, WLSL_PAGE: begin
          pc_q    <= pc_q + 16'h0001;
          busAddr <= pc_q + 16'h0001;
          if (state_q == WLSL_FETCH) begin
            pageY_q <= 1'b0;
          end
          if (state_q == WLSL_FETCH && (busRdData == OP_PAGE_Y ||
              busRdData == OP_PAGE_XY || busRdData == OP_PAGE_CD)) begin
            state_q <= WLSL_PAGE;
            // these two prefixes take the second index as the base
            pageY_q <= (busRdData == OP_PAGE_Y ||
                        busRdData == OP_PAGE_CD);
            opc_q   <= busRdData;
          end else if (!decodeOk(busRdData)) begin
            state_q   <= WLSL_BAD;
            illegalOp <= 1'b1;
          end else begin
            opc_q     <= busRdData;
            isShift_q <= busRdData[3:0] == 4'h8 ||
                         busRdData == OP_SHL_DBL;
            case (busRdData[5:4])
              2'b00:   am_q <= WLSL_AM_IMM;
              2'b01:   am_q <= WLSL_AM_DIR;
              2'b11:   am_q <= WLSL_AM_EXT;
              default: am_q <= WLSL_AM_IND;
            endcase
            if (busRdData == OP_LDD_IMM || busRdData == OP_LDD_DIR ||
                busRdData == OP_LDD_EXT || busRdData == OP_LDD_IND) begin
              tgt_q <= WLSL_TGT_D;
            end else if (busRdData[7:4] == OP_LDS_IMM[7:4] ||
                busRdData[7:4] == OP_LDS_DIR[7:4] ||
                busRdData == OP_LDS_EXT ||
                (busRdData == OP_LDS_IND && opc_q != OP_PAGE_CD)) begin
              tgt_q <= WLSL_TGT_S;
            end else if (state_q == WLSL_PAGE && (opc_q == OP_PAGE_Y ||
                opc_q == OP_PAGE_XY)) begin
              tgt_q <= WLSL_TGT_Y;
            end else begin
              tgt_q <= WLSL_TGT_X;
            end
            if (busRdData[3:0] == 4'h8 && busRdData[7:6] == 2'b01 &&
                busRdData[5:4] != 2'b11 && busRdData[5:4] != 2'b10) begin
              state_q <= WLSL_INH;
              busAddr <= IDLE_ADDR;
            end else if (busRdData == OP_SHL_DBL) begin
              state_q <= WLSL_INH;
              busAddr <= IDLE_ADDR;
            end else begin
              state_q <= WLSL_OPA;
            end
          end
        end
        WLSL_OPA: begin
          pc_q <= pc_q + 16'h0001;
          if (am_q == WLSL_AM_IMM) begin
            hiByte_q <= busRdData;
            busAddr  <= pc_q + 16'h0001;
            state_q  <= WLSL_RDLO;
          end else if (am_q == WLSL_AM_DIR) begin
            ea_q    <= {ZERO_BYTE, busRdData};
            busAddr <= {ZERO_BYTE, busRdData};
            state_q <= WLSL_RDHI;
          end else if (am_q == WLSL_AM_EXT) begin
            hiByte_q <= busRdData;
            busAddr  <= pc_q + 16'h0001;
            state_q  <= WLSL_OPB;
          end else begin
            // base chosen here; the sum waits one idle cycle
            ea_q    <= (pageY_q ? secondIndexReg : firstIndexReg) +
                       {ZERO_BYTE, busRdData};
            busAddr <= IDLE_ADDR;
            state_q <= WLSL_IDX;
          end
        end
        WLSL_OPB: begin
          pc_q    <= pc_q + 16'h0001;
          ea_q    <= {hiByte_q, busRdData};
          busAddr <= {hiByte_q, busRdData};
          state_q <= isShift_q ? WLSL_RDM : WLSL_RDHI;
        end
        WLSL_IDX: begin
          busAddr <= ea_q;
          state_q <= isShift_q ? WLSL_RDM : WLSL_RDHI;
        end
        WLSL_RDHI: begin
          hiByte_q <= busRdData;
          busAddr  <= ea_q + 16'h0001;
          state_q  <= WLSL_RDLO;
        end
        WLSL_RDLO: begin
          if (am_q == WLSL_AM_IMM) begin
            pc_q    <= pc_q + 16'h0001;
            busAddr <= pc_q + 16'h0001;
          end else begin
            busAddr <= pc_q;
          end
          state_q <= WLSL_FETCH;
        end
        WLSL_RDM: begin
          busWrData <= shOut;
          busAddr   <= IDLE_ADDR;
          state_q   <= WLSL_INT;
        end
        WLSL_INT: begin
          busAddr      <= ea_q;
          busReadWrite <= 1'b0;
          state_q      <= WLSL_WR;
        end
        WLSL_WR, WLSL_INH: begin
          busAddr <= pc_q;
          state_q <= WLSL_FETCH;
        end
        default: begin
          state_q <= WLSL_BAD;
        end
      endcase
    end
  end

  // register file and flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upperAccumulator  <= ZERO_BYTE;
      lowerAccumulator  <= ZERO_BYTE;
      stackPointerReg   <= RESET_SP;
      firstIndexReg     <= ZERO_WORD;
      secondIndexReg    <= ZERO_WORD;
      conditionFlagsReg <= RESET_FLAGS;
    end else if (state_q == WLSL_RDLO) begin
      case (tgt_q)
        WLSL_TGT_D: begin
          upperAccumulator <= wideVal[15:8];
          lowerAccumulator <= wideVal[7:0];
        end
        WLSL_TGT_S: stackPointerReg <= wideVal;
        WLSL_TGT_X: firstIndexReg   <= wideVal;
        default:    secondIndexReg  <= wideVal;
      endcase
      conditionFlagsReg[FLAG_N] <= wideVal[15];
      conditionFlagsReg[FLAG_Z] <= wideVal == ZERO_WORD;
      conditionFlagsReg[FLAG_V] <= 1'b0;
    end else if (state_q == WLSL_INH && opc_q == OP_SHL_DBL) begin
      upperAccumulator <= dblOut[15:8];
      lowerAccumulator <= dblOut[7:0];
      conditionFlagsReg[FLAG_C] <= upperAccumulator[7];
      conditionFlagsReg[FLAG_N] <= dblOut[15];
      conditionFlagsReg[FLAG_Z] <= dblOut == ZERO_WORD;
      conditionFlagsReg[FLAG_V] <= dblOut[15] ^ upperAccumulator[7];
    end else if (state_q == WLSL_INH || state_q == WLSL_RDM) begin
      if (state_q == WLSL_INH && opc_q == OP_SHL_UP) begin
        upperAccumulator <= shOut;
      end else if (state_q == WLSL_INH) begin
        lowerAccumulator <= shOut;
      end
      conditionFlagsReg[FLAG_C] <= shIn[7];
      conditionFlagsReg[FLAG_N] <= shOut[7];
      conditionFlagsReg[FLAG_Z] <= shOut == ZERO_BYTE;
      conditionFlagsReg[FLAG_V] <= shOut[7] ^ shIn[7];
    end
  end

  // checks
  wideLoadFlags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_RDLO |=> conditionFlagsReg[FLAG_V] == 1'b0 &&
      conditionFlagsReg[FLAG_N] == $past(wideVal[15]))
    else $error("wide load flags wrong");
  doubleSplit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_RDLO && tgt_q == WLSL_TGT_D |=>
      upperAccumulator == $past(hiByte_q) &&
      lowerAccumulator == $past(busRdData))
    else $error("double load byte order wrong");
  nextAddr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_RDHI |=> busAddr == $past(ea_q) + 16'h0001)
    else $error("second byte address wrong");
  stackLoad_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_RDLO && tgt_q == WLSL_TGT_S |=>
      stackPointerReg[15:8] == $past(hiByte_q))
    else $error("stack pointer load wrong");
  shiftCarry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_RDM |=> conditionFlagsReg[FLAG_C] ==
      $past(busRdData[7]) && busWrData == {$past(busRdData[6:0]), 1'b0})
    else $error("byte shift carry wrong");
  shiftOvf_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_INH |=> conditionFlagsReg[FLAG_V] ==
      (conditionFlagsReg[FLAG_N] ^ conditionFlagsReg[FLAG_C]))
    else $error("shift overflow wrong");
  dblShift_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_INH && opc_q == OP_SHL_DBL |=>
      upperAccumulator[0] == $past(lowerAccumulator[7]) &&
      lowerAccumulator[0] == 1'b0)
    else $error("double shift wrong");
  writeBack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == WLSL_RDM |-> ##1 busAddr == IDLE_ADDR ##1
      (!busReadWrite && busAddr == ea_q))
    else $error("memory shift write-back wrong");
endmodule // wlsl_core

// File: verilog/wlsl_pkg.sv
// constants and types for the wide-load and shift-left execution block
package wlsl_pkg;
  localparam logic [7:0]  OP_PAGE_Y    = 8'h18;
  localparam logic [7:0]  OP_PAGE_XY   = 8'h1A;
  localparam logic [7:0]  OP_PAGE_CD   = 8'hCD;
  localparam logic [7:0]  OP_LDD_IMM   = 8'hCC;
  localparam logic [7:0]  OP_LDD_DIR   = 8'hDC;
  localparam logic [7:0]  OP_LDD_EXT   = 8'hFC;
  localparam logic [7:0]  OP_LDD_IND   = 8'hEC;
  localparam logic [7:0]  OP_LDS_IMM   = 8'h8E;
  localparam logic [7:0]  OP_LDS_DIR   = 8'h9E;
  localparam logic [7:0]  OP_LDS_EXT   = 8'hBE;
  localparam logic [7:0]  OP_LDS_IND   = 8'hAE;
  localparam logic [7:0]  OP_LDX_IMM   = 8'hCE;
  localparam logic [7:0]  OP_LDX_DIR   = 8'hDE;
  localparam logic [7:0]  OP_LDX_EXT   = 8'hFE;
  localparam logic [7:0]  OP_LDX_IND   = 8'hEE;
  localparam logic [7:0]  OP_SHL_UP    = 8'h48;
  localparam logic [7:0]  OP_SHL_LO    = 8'h58;
  localparam logic [7:0]  OP_SHL_EXT   = 8'h78;
  localparam logic [7:0]  OP_SHL_IND   = 8'h68;
  localparam logic [7:0]  OP_SHL_DBL   = 8'h05;
  localparam logic [15:0] IDLE_ADDR    = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [15:0] RESET_PC     = 16'h0000;
  localparam logic [15:0] RESET_SP     = 16'h00FF;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  // flag field positions in condition_flags_reg
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam logic [7:0]  RESET_FLAGS  = 8'hD0;
  typedef enum {
    WLSL_FETCH, WLSL_PAGE, WLSL_OPA, WLSL_OPB, WLSL_IDX,
    WLSL_RDHI, WLSL_RDLO, WLSL_RDM, WLSL_INT, WLSL_WR, WLSL_INH,
    WLSL_BAD
  } wlsl_state_t;
  typedef enum {
    WLSL_TGT_D, WLSL_TGT_S, WLSL_TGT_X, WLSL_TGT_Y
  } wlsl_tgt_t;
  typedef enum {
    WLSL_AM_IMM, WLSL_AM_DIR, WLSL_AM_EXT, WLSL_AM_IND
  } wlsl_am_t;
endpackage

// File: tb/wlsl_mem.sv
// memory and peripheral space model facing the core bus
module wlsl_mem (
  // clock
  input  wire logic        sys_clk,
  // processor bus
  input  wire logic [15:0] busAddr,
  input  wire logic        busReadWrite,
  input  wire logic [7:0]  busWrData,
  output logic [7:0]       busRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // zero-wait read; in a write cycle the core owns the data lines,
  // so the inverse is returned, never a stale byte
  assign busRdData = busReadWrite ? mem[busAddr] : ~busWrData;
  always @(posedge sys_clk) begin
    if (busReadWrite === 1'h0) begin
      mem[busAddr] <= busWrData;
    end
  end
endmodule // wlsl_mem

// File: tb/wlsl_core_tb_top.sv
// self-checking bench for the wide-load and shift-left core
module wlsl_core_tb_top;
  import wlsl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic        isFinal;
    logic [15:0] w0, w1, w2, w3;
    logic [7:0]  f;
  } wlsl_note_t;
  typedef logic [7:0] wlsl_bytes_t [$];
  logic        sys_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [15:0] busAddr;
  logic        busReadWrite;
  logic [7:0]  busWrData;
  logic [7:0]  busRdData;
  logic [7:0]  upperAccumulator;
  logic [7:0]  lowerAccumulator;
  logic [15:0] stackPointerReg;
  logic [15:0] firstIndexReg;
  logic [15:0] secondIndexReg;
  logic [7:0]  conditionFlagsReg;
  logic        illegalOp;
  logic        prevHalt = 1'h0;
  wlsl_note_t  exp[$];
  int          err_count = 0;
  int          comparisons = 0;

  always #25 sys_clk = ~sys_clk;

  wlsl_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .busAddr(busAddr),
    .busReadWrite(busReadWrite), .busWrData(busWrData),
    .busRdData(busRdData), .upperAccumulator(upperAccumulator),
    .lowerAccumulator(lowerAccumulator), .stackPointerReg(stackPointerReg),
    .firstIndexReg(firstIndexReg), .secondIndexReg(secondIndexReg),
    .conditionFlagsReg(conditionFlagsReg), .illegalOp(illegalOp));
  wlsl_mem i_mem (.sys_clk(sys_clk), .busAddr(busAddr),
    .busReadWrite(busReadWrite), .busWrData(busWrData),
    .busRdData(busRdData));

  task automatic fail(input string msg);
    err_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic wlsl_note_t fin(logic [15:0] d, sp, x, y,
                                     logic [7:0] f);
    fin = '{1'h1, d, sp, x, y, f};
  endfunction

  function automatic wlsl_note_t wr(logic [15:0] a, logic [7:0] v);
    wr = '{1'h0, a, ZERO_WORD, ZERO_WORD, ZERO_WORD, v};
  endfunction

  // upper nibble keeps its reset pattern, loads and shifts never touch it
  function automatic logic [7:0] flg(logic n, z, v, c);
    flg = {4'hD, n, z, v, c};
  endfunction

  task automatic poke(input logic [15:0] a, input logic [15:0] w);
    i_mem.mem[a] = w[15:8];
    i_mem.mem[a + 16'h0001] = w[7:0];
  endtask

  // program is placed while the core is held, so no fetch sees it half made
  task automatic hold_reset(input wlsl_bytes_t p);
    rst_n <= 1'h0;
    repeat (8) @(posedge sys_clk);
    foreach (p[i]) i_mem.mem[i] = p[i];
  endtask

  // every program ends on an unsupported byte, so the halt marks its end
  task automatic run_prog();
    rst_n <= 1'h1;
    for (int k = 0; k < 200 && exp.size() > 0; k++) @(posedge sys_clk);
    if (exp.size() != 0) begin
      fail("program did not finish");
      exp.delete();
    end
  endtask

  // results are taken at the falling edge, where registered outputs settle
  always @(negedge sys_clk) begin
    wlsl_note_t n;
    if (rst_n === 1'h1 && (busReadWrite === 1'h0 ||
        (illegalOp === 1'h1 && !prevHalt))) begin
      if (exp.size() == 0) begin
        fail("result with no expectation");
      end else begin
        n = exp.pop_front();
        if (busReadWrite === 1'h0) begin
          comparisons++;
          if (n.isFinal || {busAddr, busWrData} !== {n.w0, n.f}) fail("write-back");
        end else begin
          comparisons += 5;
          if ({upperAccumulator, lowerAccumulator} !== n.w0) fail("double acc");
          if (stackPointerReg !== n.w1) fail("stack pointer");
          if (firstIndexReg !== n.w2) fail("first index");
          if (secondIndexReg !== n.w3) fail("second index");
          if (conditionFlagsReg !== n.f) fail("flags");
        end
      end
    end
    prevHalt = (illegalOp === 1'h1);
  end

  initial begin
    repeat (4000) @(posedge sys_clk);
    fail("watchdog expired");
    complete_run();
  end

  initial begin
    logic [15:0] d, s, x, y;
    logic [7:0]  m1, m2;
    void'($urandom(92626));
    i_mem.mem[16'hFFFF] = 8'($urandom);
    // immediate loads of all four targets, second index through prefix
    d = 16'($urandom);
    s = 16'($urandom);
    x = 16'($urandom);
    y = 16'($urandom);
    hold_reset('{OP_LDD_IMM, d[15:8], d[7:0], OP_LDS_IMM, s[15:8], s[7:0],
      OP_LDX_IMM, x[15:8], x[7:0], OP_PAGE_Y, OP_LDX_IMM, y[15:8], y[7:0],
      ZERO_BYTE});
    exp.push_back(fin(d, s, x, y, flg(y[15], y == 16'h0000, 1'h0, 1'h0)));
    run_prog();
    // direct, extended and prefixed indexed forms; last word is zero
    d = 16'($urandom);
    s = 16'($urandom);
    x = 16'($urandom);
    hold_reset('{OP_LDD_DIR, 8'h40, OP_LDS_EXT, 8'h02, 8'h00, OP_LDX_EXT,
      8'h03, 8'h00, OP_PAGE_Y, OP_LDX_IND, 8'h10, ZERO_BYTE});
    poke(16'h0040, d);
    poke(16'h0200, s);
    poke(16'h0300, x);
    poke(16'h0010, ZERO_WORD);
    exp.push_back(fin(d, s, x, ZERO_WORD, flg(1'h0, 1'h1, 1'h0, 1'h0)));
    run_prog();
    // prefixed forms: first-index base to second target, then the reverse
    x = 16'($urandom);
    hold_reset('{OP_LDX_IMM, 8'h01, 8'h00, OP_PAGE_XY, OP_LDX_IND, 8'h10,
      OP_PAGE_CD, OP_LDX_IND, 8'h20, ZERO_BYTE});
    poke(16'h0110, 16'h0300);
    poke(16'h0320, x);
    exp.push_back(fin(ZERO_WORD, RESET_SP, x, 16'h0300,
      flg(x[15], x == 16'h0000, 1'h0, 1'h0)));
    run_prog();
    // both accumulators, then extended and indexed memory bytes
    repeat (3) begin
      d = 16'($urandom);
      m1 = 8'($urandom);
      m2 = 8'($urandom);
      hold_reset('{OP_LDD_IMM, d[15:8], d[7:0], OP_SHL_UP, OP_SHL_LO,
        OP_SHL_EXT, 8'h05, 8'h00, OP_SHL_IND, 8'h20, ZERO_BYTE});
      i_mem.mem[16'h0500] = m1;
      i_mem.mem[16'h0020] = m2;
      exp.push_back(wr(16'h0500, {m1[6:0], 1'h0}));
      exp.push_back(wr(16'h0020, {m2[6:0], 1'h0}));
      exp.push_back(fin({d[14:8], 1'h0, d[6:0], 1'h0}, RESET_SP, ZERO_WORD,
        ZERO_WORD, flg(m2[6], m2[6:0] == 7'h00, m2[6] ^ m2[7], m2[7])));
      run_prog();
    end
    // double shift; first pass moves the lone top bit out to carry
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 16'h8000 : 16'($urandom);
      hold_reset('{OP_LDD_IMM, d[15:8], d[7:0], OP_SHL_DBL, ZERO_BYTE});
      exp.push_back(fin({d[14:0], 1'h0}, RESET_SP, ZERO_WORD, ZERO_WORD,
        flg(d[14], d[14:0] == 15'h0000, d[14] ^ d[15], d[15])));
      run_prog();
    end
    complete_run();
  end
endmodule // wlsl_core_tb_top
